// ==== dv/omc_ext_mem.sv ====
/* omc_ext_mem: byte-wide external memory on ports A/B and C.
   Assumes narrow transfers of two beats, one per clock. */
`default_nettype none
module omc_ext_mem (
  input wire logic core_clk,
  input wire logic narrow_busy,
  input wire logic [15:0] port_ab_addr,
  input wire logic [7:0] port_c_data,
  output logic [15:0] word_seen,
  output logic [15:0] word_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic beat2 = 1'b0;
  // a wrong second address spoils the low byte so the bench sees it
  always @(posedge core_clk) begin
    if (narrow_busy && !beat2) begin
      word_seen[15:8] <= port_c_data;
      word_addr <= port_ab_addr;
      beat2 <= 1'b1;
    end else if (beat2) begin
      word_seen[7:0] <= (port_ab_addr == word_addr + 16'h0001) ? port_c_data : ~port_c_data;
      beat2 <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/omc_properties.sv ====
/* omc_checker: port assertions for omc_top.
   Assumes one clock domain, sync reset, bound into every omc_top. */
`default_nettype none
module omc_checker
  import omc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic narrow_busy,
  input wire logic [15:0] port_ab_addr,
  input wire logic port_ab_bus,
  input wire logic port_c_bus,
  input wire logic port_d_bus,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_req,
  input wire logic debug_active,
  input wire logic debug_enabled,
  input wire logic dbg_rom_sel,
  input wire logic dbg_reg_sel,
  input wire logic user_top_hidden
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // assertions
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_low_byte;
    port_ab_addr == $past(port_ab_addr) + 16'h0001;
  endsequence
  sequence s_done;
    !narrow_busy;
  endsequence
  a_narrow_pair: assert property ($rose(narrow_busy) |=> s_low_byte ##1 s_done)
    else $error("narrow second beat out of step");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_setup_answer: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_data_addr: assert property ($rose(narrow_busy) |-> port_ab_bus && port_c_bus)
    else $error("data bus without address bus");
  a_wide_data: assert property (port_d_bus |-> port_c_bus)
    else $error("port d bus without port c");
  a_rom_map: assert property (debug_active && clk_en && cpu_req && cpu_addr >= OMC_DBG_ROM_LO
    |=> dbg_rom_sel)
    else $error("debug rom not selected");
  a_reg_map: assert property (debug_active && clk_en && cpu_req && cpu_addr >= OMC_DBG_REG_LO
    && cpu_addr <= OMC_DBG_REG_HI |=> dbg_reg_sel)
    else $error("debug registers not selected");
  a_top_hide: assert property (debug_active && clk_en && cpu_req && cpu_addr[15:8] == OMC_TOP_PAGE
    |=> user_top_hidden)
    else $error("top page not hidden");
  a_active_enabled: assert property ($rose(debug_active) |-> debug_enabled)
    else $error("debug active while disabled");
endmodule
bind omc_top omc_checker i_omc_checker (.core_clk, .sys_rst, .clk_en, .psel, .penable, .pready, .pslverr,
  .narrow_busy, .port_ab_addr, .port_ab_bus, .port_c_bus, .port_d_bus, .cpu_addr, .cpu_req, .debug_active,
  .debug_enabled, .dbg_rom_sel, .dbg_reg_sel, .user_top_hidden);
`default_nettype wire

// ==== dv/omc_top_tb.sv ====
/* omc_top_tb: self-checking bench for omc_top.
   Assumes a one-cycle APB answer and a 10 MHz core clock. */
`default_nettype none
module omc_top_tb
  import omc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, cpu_internal = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_req = 1'b0, cpu_wide = 1'b0;
  logic debug_serial_pin = 1'b0, mode_pin_b = 1'b0, mode_pin_a = 1'b0;
  logic debug_serial_activate = 1'b0, debug_entry_instruction = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000, port_ab_addr, word_seen, word_addr;
  logic [7:0] port_c_data, port_d_data;
  logic pready, pslverr, cpu_run, port_c_bus, port_d_bus, port_ab_bus, bus_clk, narrow_busy, er, b;
  logic debug_active, debug_enabled, dbg_rom_sel, dbg_reg_sel, user_top_hidden;
  logic [2:0] c;
  int error_cnt = 0, checks = 0;
  // row: pin code, refused flag, mode register after reset
  logic [11:0] rows [8] = '{12'h01B, 12'h23B, 12'h500, 12'h67B, 12'h890, 12'hAB0, 12'hD00, 12'hEF0};
  always #50 core_clk = ~core_clk;
  omc_top i_omc_top (.core_clk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .debug_serial_pin, .mode_pin_b, .mode_pin_a, .debug_serial_activate,
    .debug_entry_instruction, .cpu_req, .cpu_wide, .cpu_addr, .cpu_wdata, .cpu_internal, .cpu_run,
    .port_ab_addr, .port_c_data, .port_d_data, .port_c_bus, .port_d_bus, .port_ab_bus, .bus_clk,
    .narrow_busy, .debug_active, .debug_enabled, .dbg_rom_sel, .dbg_reg_sel, .user_top_hidden);
  omc_ext_mem i_omc_ext_mem (.core_clk, .narrow_busy, .port_ab_addr, .port_c_data, .word_seen, .word_addr);
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic [2:0] code);
    @(posedge core_clk);
    {debug_serial_pin, mode_pin_b, mode_pin_a} <= code;
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic dbg_pulse(input int s);
    @(posedge core_clk) {debug_serial_activate, debug_entry_instruction} <= 2'b01 << s;
    @(posedge core_clk) {debug_serial_activate, debug_entry_instruction} <= 2'b00;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    for (int i = 0; i < 8; i++) begin
      c = rows[i][11:9];
      rst(c);
      chk("cpu_run", 32'(cpu_run), 32'(c[1:0] != 2'b10));
      chk("ab_bus", 32'(port_ab_bus), 32'(c[1:0] != 2'b00));
      chk("c_bus", 32'(port_c_bus), 32'(c[1:0] != 2'b00));
      chk("d_bus", 32'(port_d_bus), 32'(c[1]));
      chk("dbg_on", 32'(debug_active), 32'(c == 3'b000));
      apb(1'b0, OMC_MODE_OFF, 32'h0);
      chk("mode_err", 32'(er), 32'(rows[i][8]));
      if (!rows[i][8]) chk("mode", rd, {24'h0, rows[i][7:0]});
    end
    rst(3'b111);
    apb(1'b1, OMC_MODE_OFF, 32'hA0);
    apb(1'b1, OMC_MODE_OFF, 32'h70);
    apb(1'b0, OMC_MODE_OFF, 32'h0);
    chk("mode_once", rd, 32'hA0);
    chk("d_narrow", 32'(port_d_bus), 32'h0);
    #1 b = bus_clk;
    @(posedge core_clk) #1 chk("bus_clk", 32'(bus_clk), 32'(!b));
    @(posedge core_clk) {cpu_req, cpu_wide, cpu_addr, cpu_wdata} <= {2'b11, 16'h1234, 16'hABCD};
    @(posedge core_clk) cpu_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("narrow_word", {16'h0, word_seen}, 32'hABCD);
    chk("narrow_addr", {16'h0, word_addr}, 32'h1234);
    rst(3'b001);
    @(posedge core_clk) {cpu_req, cpu_internal, cpu_wdata} <= {2'b11, 16'h5AC3};
    @(posedge core_clk) {cpu_req, cpu_internal} <= 2'b00;
    #1 chk("vis_wide", {16'h0, port_c_data, port_d_data}, 32'h5AC3);
    chk("vis_d_bus", 32'(port_d_bus), 32'h1);
    chk("stretch_hi", 32'(bus_clk), 32'h1);
    rst(3'b000);
    apb(1'b1, OMC_MODE_OFF, 32'h9B);
    apb(1'b1, OMC_MODE_OFF, 32'h5B);
    apb(1'b0, OMC_MODE_OFF, 32'h0);
    chk("mode_sp", rd, 32'h1B);
    apb(1'b1, OMC_MODE_OFF, 32'hBB);
    apb(1'b0, OMC_MODE_OFF, 32'h0);
    chk("mode_norm", rd, 32'hBB);
    chk("c_bus_sw", 32'(port_c_bus), 32'h1);
    @(posedge core_clk) {cpu_req, cpu_addr} <= {1'b1, 16'hFF03};
    @(posedge core_clk) cpu_addr <= 16'hFF40;
    #1 chk("reg_sel", 32'(dbg_reg_sel), 32'h1);
    chk("top_hide", 32'(user_top_hidden), 32'h1);
    @(posedge core_clk) cpu_req <= 1'b0;
    #1 chk("rom_sel", 32'(dbg_rom_sel), 32'h1);
    for (int s = 0; s < 2; s++) begin
      rst(3'b100); // debug requests are only made outside peripheral mode
      dbg_pulse(s);
      chk("dbg_locked", 32'(debug_active), 32'h0);
      apb(1'b1, OMC_DBG_OFF, 32'h1);
      dbg_pulse(s);
      apb(1'b0, OMC_DBG_OFF, 32'h0);
      chk("dbg_go", rd, 32'h3);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    finish_test();
  end
  // the whole run needs a few hundred cycles; this bounds a hang
  initial begin
    #3000000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire

// ==== rtl/omc_pkg.sv ====
/*
  omc_pkg: constants for the operating-mode control block.
  Assumes an 8-bit mode register placed in a 32-bit APB word.
*/
`default_nettype none
package omc_pkg;
  // ********************************
  // register map
  // ********************************
  localparam logic [11:0] OMC_MODE_OFF = 12'h00B;
  localparam logic [11:0] OMC_DBG_OFF = 12'h010;
  localparam logic [11:0] OMC_BUS_OFF = 12'h014;
  localparam logic [11:0] OMC_STAT_OFF = 12'h018;
  // ********************************
  // mode register fields
  // ********************************
  localparam int OMC_SPECIAL_MODE_FLAG_LOW_BIT = 7;
  localparam int OMC_MODE_SELECT_UPPER_BIT = 6;
  localparam int OMC_MODE_SELECT_LOWER_BIT = 5;
  localparam int OMC_BUS_CLOCK_STRETCH_ENABLE_BIT = 4;
  localparam int OMC_INTERNAL_ACCESS_VISIBLE_BIT = 3;
  localparam int OMC_EMD_BIT = 1;
  localparam int OMC_EME_BIT = 0;
  localparam int OMC_ZERO_BIT = 2;
  // ********************************
  // mode register reset images
  // ********************************
  localparam logic [4:0] OMC_RST_SPECIAL_LOW = 5'h1B;
  localparam logic [4:0] OMC_RST_NORMAL_LOW = 5'h10;
  localparam logic [7:0] OMC_RST_PERIPH = 8'h5B;
  // ********************************
  // debug memory overlay
  // ********************************
  localparam logic [15:0] OMC_DBG_ROM_LO = 16'hFF20;
  localparam logic [15:0] OMC_DBG_ROM_HI = 16'hFFFF;
  localparam logic [15:0] OMC_DBG_REG_LO = 16'hFF00;
  localparam logic [15:0] OMC_DBG_REG_HI = 16'hFF06;
  localparam logic [7:0] OMC_TOP_PAGE = 8'hFF;
  // ********************************
  // modes: {debug pin, mode pin b, mode pin a}
  // ********************************
  typedef enum logic [2:0] {
    OMC_SP_SINGLE = 3'b000,
    OMC_SP_NARROW = 3'b001,
    OMC_SP_PERIPH = 3'b010,
    OMC_SP_WIDE = 3'b011,
    OMC_NM_SINGLE = 3'b100,
    OMC_NM_NARROW = 3'b101,
    OMC_NM_RESVD = 3'b110,
    OMC_NM_WIDE = 3'b111
  } omc_mode_t;
  typedef enum logic [1:0] {
    OMC_BUS_NONE = 2'b00,
    OMC_BUS_NARROW = 2'b01,
    OMC_BUS_WIDE = 2'b10,
    OMC_BUS_PERIPH = 2'b11
  } omc_bus_t;
  typedef enum logic [1:0] {
    OMC_NS_IDLE = 2'b00,
    OMC_NS_HIGH = 2'b01,
    OMC_NS_LOW = 2'b10
  } omc_nstate_t;
endpackage
`default_nettype wire

// ==== rtl/omc_top.sv ====
/*
  omc_top: operating-mode control. Latches mode pins at reset, holds the mode
  register, arranges the external bus, stretches the bus clock and runs the
  debug memory overlay.
  Assumes an APB master on core_clk, synchronous pins, one clock domain.
*/
// Overview of operation
// - reset decodes debug pin and two mode pins; code 110 forced to peripheral
// - normal wide: 16-bit address on ports A/B, data on C and D
// - normal narrow: port C 8-bit data, high byte then low byte
// - narrow 16-bit transfer increments address on second byte cycle
// - single chip: no external buses, ports free for general I/O
// - special wide: same bus arrangement as normal wide
// - special narrow: two consecutive port C cycles, high then low
// - special narrow with port-D emulate and visibility shows internal data wide
// - special single chip enters active debug with no external bus
// - peripheral mode: processor held inactive, external master drives peripherals
// - switching into or out of peripheral mode only by reset
// - debug enabled and active at reset in special single chip only
// - enabled debug activates on serial command or entry instruction
// - active debug maps ROM at FF20-FFFF, supplying vectors
// - active debug maps debug registers at FF00-FF06
// - active debug hides user top page from normal accesses
// - mode register bit layout with bit 2 reading zero
// - mode register absent from map in peripheral mode
// - mode bits capture pins at reset release, readable outside peripheral mode
// - special flag writable only while zero, first write ignored
// - mode select write-once or anytime; never peripheral or reserved
// - stretch disabled: bus clock free running
// - stretch enabled: high on external cycles, low on hidden internal ones
// - stretch enable write-once in normal modes, anytime in special
`default_nettype none
module omc_top
  import omc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_serial_pin,
  input wire logic mode_pin_b,
  input wire logic mode_pin_a,
  input wire logic debug_serial_activate,
  input wire logic debug_entry_instruction,
  input wire logic cpu_req,
  input wire logic cpu_wide,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_internal,
  output logic cpu_run,
  output logic [15:0] port_ab_addr,
  output logic [7:0] port_c_data,
  output logic [7:0] port_d_data,
  output logic port_c_bus,
  output logic port_d_bus,
  output logic port_ab_bus,
  output logic bus_clk,
  output logic narrow_busy,
  output logic debug_active,
  output logic debug_enabled,
  output logic dbg_rom_sel,
  output logic dbg_reg_sel,
  output logic user_top_hidden
);
  // ********************************
  // mode register and reset capture
  // ********************************
  logic [7:0] mode_reg;
  logic special_mode_flag_low_written;
  logic modsel_written;
  logic bus_clock_stretch_enable_written;
  logic [1:0] rst_hist;
  logic [2:0] pin_code;
  omc_mode_t mode;
  omc_bus_t bus_kind;
  omc_nstate_t nstate;
  logic ap_wr;
  logic ap_rd;
  logic mode_hit;
  logic [1:0] next_modsel;
  logic special;

  assign pin_code = {debug_serial_pin, mode_pin_b, mode_pin_a};
  assign mode = omc_mode_t'(mode_reg[OMC_SPECIAL_MODE_FLAG_LOW_BIT:OMC_MODE_SELECT_LOWER_BIT]);
  assign special = ~mode_reg[OMC_SPECIAL_MODE_FLAG_LOW_BIT];
  assign ap_wr = psel && penable && pwrite && clk_en;
  assign ap_rd = psel && penable && !pwrite && clk_en;
  assign mode_hit = (paddr == OMC_MODE_OFF) && (mode != OMC_SP_PERIPH);
  assign next_modsel = pwdata[OMC_MODE_SELECT_UPPER_BIT:OMC_MODE_SELECT_LOWER_BIT];

  // reset is synchronous; the pins are sampled on the first cycle after release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_hist <= 2'b11;
    end else if (clk_en) begin
      rst_hist <= {rst_hist[0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_reg <= 8'h00;
      special_mode_flag_low_written <= 1'b0;
      modsel_written <= 1'b0;
      bus_clock_stretch_enable_written <= 1'b0;
    end else if (clk_en) begin
      if (rst_hist[0]) begin
        // reserved code forced to peripheral
        if (pin_code == OMC_NM_RESVD) begin
          mode_reg <= OMC_RST_PERIPH;
        end else if (pin_code[2]) begin
          mode_reg <= {pin_code, OMC_RST_NORMAL_LOW};
        end else begin
          mode_reg <= {pin_code, OMC_RST_SPECIAL_LOW};
        end
      end else if (ap_wr && mode_hit && pstrb[0]) begin
        // special flag: only while zero, first write swallowed
        if (special) begin
          special_mode_flag_low_written <= 1'b1;
          if (special_mode_flag_low_written) begin
            mode_reg[OMC_SPECIAL_MODE_FLAG_LOW_BIT] <= pwdata[OMC_SPECIAL_MODE_FLAG_LOW_BIT];
          end
        end
        // mode select guarded against peripheral and reserved
        if ((special || !modsel_written) && (next_modsel != 2'b10)) begin
          mode_reg[OMC_MODE_SELECT_UPPER_BIT:OMC_MODE_SELECT_LOWER_BIT] <= next_modsel;
          modsel_written <= 1'b1;
        end
        // stretch enable write-once in normal modes
        if (special || !bus_clock_stretch_enable_written) begin
          mode_reg[OMC_BUS_CLOCK_STRETCH_ENABLE_BIT] <= pwdata[OMC_BUS_CLOCK_STRETCH_ENABLE_BIT];
          bus_clock_stretch_enable_written <= 1'b1;
        end
        if (special) begin
          mode_reg[OMC_INTERNAL_ACCESS_VISIBLE_BIT] <= pwdata[OMC_INTERNAL_ACCESS_VISIBLE_BIT];
          mode_reg[OMC_EMD_BIT] <= pwdata[OMC_EMD_BIT];
          mode_reg[OMC_EME_BIT] <= pwdata[OMC_EME_BIT];
        end
        mode_reg[OMC_ZERO_BIT] <= 1'b0;
      end
    end
  end

  // ********************************
  // debug facility
  // ********************************
  logic dbg_en_sw;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      debug_enabled <= 1'b0;
      debug_active <= 1'b0;
    end else if (clk_en) begin
      if (rst_hist[0]) begin
        debug_enabled <= (pin_code == OMC_SP_SINGLE);
        debug_active <= (pin_code == OMC_SP_SINGLE);
      end else begin
        debug_enabled <= debug_enabled || dbg_en_sw;
        if ((debug_enabled || dbg_en_sw) && (debug_serial_activate || debug_entry_instruction)) begin
          debug_active <= 1'b1;
        end
      end
    end
  end

  logic dbg_wr;
  assign dbg_wr = ap_wr && (paddr == OMC_DBG_OFF) && pstrb[0];
  assign dbg_en_sw = dbg_wr && pwdata[0];

  // overlay decodes of the processor address
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dbg_rom_sel <= 1'b0;
      dbg_reg_sel <= 1'b0;
      user_top_hidden <= 1'b0;
    end else if (clk_en) begin
      dbg_rom_sel <= debug_active && cpu_req && cpu_addr >= OMC_DBG_ROM_LO && cpu_addr <= OMC_DBG_ROM_HI;
      dbg_reg_sel <= debug_active && cpu_req && cpu_addr >= OMC_DBG_REG_LO && cpu_addr <= OMC_DBG_REG_HI;
      user_top_hidden <= debug_active && cpu_req && (cpu_addr[15:8] == OMC_TOP_PAGE);
    end
  end

  // ********************************
  // bus arrangement
  // ********************************
  always_comb begin
    bus_kind = OMC_BUS_NONE;
    unique case (mode)
      OMC_SP_SINGLE, OMC_NM_SINGLE: bus_kind = OMC_BUS_NONE;
      OMC_SP_NARROW, OMC_NM_NARROW: bus_kind = OMC_BUS_NARROW;
      OMC_SP_WIDE, OMC_NM_WIDE: bus_kind = OMC_BUS_WIDE;
      OMC_SP_PERIPH, OMC_NM_RESVD: bus_kind = OMC_BUS_PERIPH;
    endcase
  end

  logic visible;
  logic ext_cycle;
  logic wide_vis;
  assign visible = mode_reg[OMC_INTERNAL_ACCESS_VISIBLE_BIT] && (bus_kind != OMC_BUS_NONE);
  assign ext_cycle = cpu_req && (!cpu_internal || visible) && (bus_kind != OMC_BUS_NONE);
  assign wide_vis = (mode == OMC_SP_NARROW) && mode_reg[OMC_EMD_BIT] && mode_reg[OMC_INTERNAL_ACCESS_VISIBLE_BIT] && cpu_internal;

  logic [7:0] low_byte;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nstate <= OMC_NS_IDLE;
      low_byte <= 8'h00;
      port_ab_addr <= 16'h0000;
      port_c_data <= 8'h00;
      port_d_data <= 8'h00;
      narrow_busy <= 1'b0;
    end else if (clk_en) begin
      unique case (nstate)
        OMC_NS_IDLE: begin
          narrow_busy <= 1'b0;
          if (ext_cycle && bus_kind != OMC_BUS_PERIPH) begin
            port_ab_addr <= cpu_addr;
            if (bus_kind == OMC_BUS_WIDE || wide_vis || (bus_kind == OMC_BUS_NARROW && !cpu_wide)) begin
              port_c_data <= cpu_wdata[15:8];
              port_d_data <= cpu_wdata[7:0];
            end else begin
              port_c_data <= cpu_wdata[15:8]; // high byte first
              low_byte <= cpu_wdata[7:0];
              narrow_busy <= 1'b1;
              nstate <= OMC_NS_HIGH;
            end
          end
        end
        OMC_NS_HIGH: begin
          port_ab_addr <= port_ab_addr + 16'h0001;
          port_c_data <= low_byte;
          nstate <= OMC_NS_LOW;
        end
        OMC_NS_LOW: begin
          narrow_busy <= 1'b0;
          nstate <= OMC_NS_IDLE;
        end
        default: nstate <= OMC_NS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_ab_bus <= 1'b0;
      port_c_bus <= 1'b0;
      port_d_bus <= 1'b0;
      cpu_run <= 1'b0;
    end else if (clk_en) begin
      port_ab_bus <= (bus_kind != OMC_BUS_NONE);
      port_c_bus <= (bus_kind != OMC_BUS_NONE);
      port_d_bus <= (bus_kind == OMC_BUS_WIDE) || (bus_kind == OMC_BUS_PERIPH) || wide_vis;
      cpu_run <= (bus_kind != OMC_BUS_PERIPH) && !rst_hist[0];
    end
  end

  // ********************************
  // bus clock
  // ********************************
  // with stretch on, the clock holds high on external cycles and low on hidden internal ones, toggling only with no request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_clk <= 1'b0;
    end else if (clk_en) begin
      if (!mode_reg[OMC_BUS_CLOCK_STRETCH_ENABLE_BIT]) begin
        bus_clk <= ~bus_clk;
      end else if (ext_cycle || narrow_busy) begin
        bus_clk <= 1'b1;
      end else if (cpu_req) begin
        bus_clk <= 1'b0;
      end else begin
        bus_clk <= ~bus_clk;
      end
    end
  end

  // ********************************
  // apb slave
  // ********************************
  logic known;
  assign known = mode_hit || paddr == OMC_DBG_OFF || paddr == OMC_BUS_OFF || paddr == OMC_STAT_OFF;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (psel && !penable && !pwrite) begin
        if (mode_hit) begin
          prdata <= {24'h000000, mode_reg};
        end else if (paddr == OMC_DBG_OFF) begin
          prdata <= {30'h0, debug_active, debug_enabled};
        end else if (paddr == OMC_BUS_OFF) begin
          prdata <= {28'h0000000, nstate, bus_kind};
        end else if (paddr == OMC_STAT_OFF) begin
          prdata <= {29'h0, special_mode_flag_low_written, modsel_written, bus_clock_stretch_enable_written};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
  logic unused_rd;
  assign unused_rd = ap_rd;
endmodule
`default_nettype wire
